// file: design/efe_feature_enum.sv
`timescale 1ns/100ps
// Contract
// - Extended-feature leaf 07H sub-leaf 0 EBX bit 2 reports enclave support.
// - Opted in only when enable bit and lock bit 0 are both one.
// - Opt-in enable state never appears in the extended-feature leaf 07H result.
// - No support gives invalid opcode; not opted in gives general protection.
// - With support, resource leaf 12H answers through its sub-leaves.
// - Valid resource sub-leaves depend on opt-in state and configuration.
// - Resource leaf results are per hardware thread; software must not generalise.
// - Configured device returns non-zero content in at least three sub-leaves.
// - Sub-leaf 0 EAX bits 0,1 give groups; reserved bits and ECX zero.
// - Sub-leaf 0 EAX bits 5 and 6 give oversubscription leaf support.
// - Sub-leaf 0 EBX reports the misc region select mask.
// - Sub-leaf 0 EDX gives size exponents in bytes 0 and 1, rest zero.
// - Sub-leaf 1 reports the 128-bit attribute creation mask in four words.
// - Sub-leaves from 2 describe sections; walk upward until invalid type.
// - Invalid resource sub-leaf returns zero in all four result words.
// - Section type 0000b invalid, 0001b valid section, others reserved.
// - Section base bits 31:12 in EAX, bits 51:32 in EBX.
// - Section size in ECX and EDX; ECX type 0001b means protected.
module efe_feature_enum (
    input  wire logic                      clock,
    input  wire logic                      rst_n,
    input  wire logic                      query_valid,
    input  wire efe_pkg::efe_query_type    query,
    output logic                           result_valid,
    output efe_pkg::efe_result_type        result,
    input  wire logic                      ctrl_wr,
    input  wire logic [63:0]               ctrl_wdata,
    output logic [63:0]                    ctrl_rdata,
    input  wire logic                      sect_wr,
    input  wire logic [efe_pkg::SECT_IDX_W-1:0] sect_idx,
    input  wire efe_pkg::efe_sect_cfg_type sect_cfg,
    input  wire logic                      encl_req,
    input  wire logic                      encl_extra_ud,
    output efe_pkg::efe_verdict_type       encl_verdict,
    output logic                           opted_in
);
    efe_pkg::efe_top_state_type st_reg;
    efe_pkg::efe_top_state_type st_next;
    efe_pkg::efe_result_type    sect_res [efe_pkg::NUM_SECT];
    efe_pkg::efe_result_type    answer;
    logic [31:0]                sect_off;
    logic [efe_pkg::SECT_IDX_W-1:0] sect_sel;
    logic                       sect_hit;
    logic                       opted_now;

    assign opted_now = st_reg.lock && st_reg.opt_in;
    assign opted_in  = opted_now;

    // Section table is frozen together with the lock so that what firmware
    // published cannot change under the running system
    genvar gi;
    generate
        for (gi = 0; gi < efe_pkg::NUM_SECT; gi++) begin : g_sect
            efe_section_slot u_slot (
                .clock  (clock),
                .rst_n  (rst_n),
                .wr     (sect_wr && !st_reg.lock && (sect_idx == gi)),
                .cfg    (sect_cfg),
                .result (sect_res[gi])
            );
        end
    endgenerate

    assign sect_off = query.subleaf - efe_pkg::SUBLEAF_SECT0;
    assign sect_sel = sect_off[efe_pkg::SECT_IDX_W-1:0];
    assign sect_hit = (query.subleaf >= efe_pkg::SUBLEAF_SECT0)
                   && (sect_off < efe_pkg::NUM_SECT);

    // Query answer; every unlisted leaf or sub-leaf answers all zero
    always_comb begin
        answer = '0;
        if (query.leaf == efe_pkg::LEAF_EXT_FEAT) begin
            if (query.subleaf == efe_pkg::SUBLEAF_ZERO) begin
                // Opt-in state deliberately not folded in here
                answer.ebx = efe_pkg::EXT_FLAGS_OTHER;
                answer.ebx[efe_pkg::SUPPORT_POS] = efe_pkg::ENCLAVE_SUPPORTED;
            end
        end else if (query.leaf == efe_pkg::LEAF_ENCLAVE_RES
                     && efe_pkg::ENCLAVE_SUPPORTED) begin
            if (query.subleaf == efe_pkg::SUBLEAF_CAPS) begin
                answer.eax = efe_pkg::CAP_FLAGS & efe_pkg::CAP_DEFINED_MASK;
                answer.ebx = efe_pkg::MISC_SELECT;
                answer.ecx = '0;
                answer.edx = {16'h0000, efe_pkg::MAX_EXP_WIDE,
                              efe_pkg::MAX_EXP_LEGACY};
            end else if (query.subleaf == efe_pkg::SUBLEAF_ATTR) begin
                answer.eax = efe_pkg::ATTR_MASK[31:0];
                answer.ebx = efe_pkg::ATTR_MASK[63:32];
                answer.ecx = efe_pkg::ATTR_MASK[95:64];
                answer.edx = efe_pkg::ATTR_MASK[127:96];
            end else if (sect_hit && opted_now) begin
                // Sections are only published once opted in; software walks
                // upward from sub-leaf 2 until the first all-zero answer
                answer = sect_res[sect_sel];
            end
        end
    end

    always_comb begin
        st_next           = st_reg;
        st_next.res_valid = query_valid;
        st_next.verdict   = efe_pkg::EFE_IDLE;
        if (query_valid) begin
            // Per-thread: each thread has its own instance of this block
            st_next.res = answer;
        end
        if (ctrl_wr && !st_reg.lock) begin
            st_next.lock   = ctrl_wdata[efe_pkg::LOCK_POS];
            st_next.opt_in = ctrl_wdata[efe_pkg::OPT_IN_POS];
        end
        if (encl_req) begin
            // Verdict is given before any execution step may start, so a
            // fault leaves architectural and memory state untouched
            if (!efe_pkg::ENCLAVE_SUPPORTED || encl_extra_ud) begin
                st_next.verdict = efe_pkg::EFE_UD;
            end else if (!opted_now) begin
                st_next.verdict = efe_pkg::EFE_GP;
            end else begin
                st_next.verdict = efe_pkg::EFE_RUN;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= efe_pkg::TOP_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    assign result_valid = st_reg.res_valid;
    assign result       = st_reg.res;
    assign encl_verdict = st_reg.verdict;

    // Only the lock and opt-in bits are implemented; all others read zero
    always_comb begin
        ctrl_rdata = '0;
        ctrl_rdata[efe_pkg::LOCK_POS]   = st_reg.lock;
        ctrl_rdata[efe_pkg::OPT_IN_POS] = st_reg.opt_in;
    end

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    logic q_ext0;
    logic q_caps;
    logic q_attr;
    logic q_sect0;
    logic q_beyond;

    assign q_ext0   = query_valid && query.leaf == efe_pkg::LEAF_EXT_FEAT
                   && query.subleaf == efe_pkg::SUBLEAF_ZERO;
    assign q_caps   = query_valid && query.leaf == efe_pkg::LEAF_ENCLAVE_RES
                   && query.subleaf == efe_pkg::SUBLEAF_CAPS;
    assign q_attr   = query_valid && query.leaf == efe_pkg::LEAF_ENCLAVE_RES
                   && query.subleaf == efe_pkg::SUBLEAF_ATTR;
    assign q_sect0  = query_valid && query.leaf == efe_pkg::LEAF_ENCLAVE_RES
                   && query.subleaf == efe_pkg::SUBLEAF_SECT0;
    assign q_beyond = query_valid && query.leaf == efe_pkg::LEAF_ENCLAVE_RES
                   && query.subleaf >= efe_pkg::SUBLEAF_SECT0 + efe_pkg::NUM_SECT;

    support_flag_a: assert property (
        q_ext0 |=> result_valid
                && result.ebx[efe_pkg::SUPPORT_POS] == efe_pkg::ENCLAVE_SUPPORTED)
        else $error("support flag wrong in extended feature answer");

    opt_in_hidden_a: assert property (
        q_ext0 ##1 q_ext0 |=> result == $past(result))
        else $error("extended feature answer changed between queries");

    opted_state_a: assert property (
        opted_in |-> ctrl_rdata[efe_pkg::LOCK_POS] && ctrl_rdata[efe_pkg::OPT_IN_POS])
        else $error("opted in without both control bits set");

    lock_hold_a: assert property (
        st_reg.lock && ctrl_wr |=> $stable(ctrl_rdata) && st_reg.lock)
        else $error("control bits changed after lock");

    gp_fault_a: assert property (
        encl_req && !encl_extra_ud && !opted_in
        |=> encl_verdict == efe_pkg::EFE_GP)
        else $error("missing protection fault when not opted in");

    ud_first_a: assert property (
        encl_req && encl_extra_ud |=> encl_verdict == efe_pkg::EFE_UD)
        else $error("invalid opcode condition did not win");

    run_only_opted_a: assert property (
        encl_verdict == efe_pkg::EFE_RUN
        |-> $past(opted_in) && !$past(encl_extra_ud) && $past(encl_req))
        else $error("enclave instruction ran while gated");

    caps_reserved_a: assert property (
        q_caps |=> result.eax[4:2] == 3'h0 && result.eax[31:7] == 25'h0000000
                && result.ecx == 32'h0000_0000)
        else $error("reserved capability bits not zero");

    size_exp_a: assert property (
        q_caps |=> result.edx[7:0] == efe_pkg::MAX_EXP_LEGACY
                && result.edx[15:8] == efe_pkg::MAX_EXP_WIDE
                && result.edx[31:16] == 16'h0000)
        else $error("size exponent word wrong");

    attr_mask_a: assert property (
        q_attr |=> {result.edx, result.ecx, result.ebx, result.eax} == efe_pkg::ATTR_MASK)
        else $error("attribute mask words wrong");

    invalid_zero_a: assert property (
        q_beyond |=> result == '0)
        else $error("invalid sub-leaf not all zero");

    sect_type_a: assert property (
        q_sect0 |=> result.eax[3:0] == efe_pkg::SECT_INVALID
                 || (result.eax[3:0] == efe_pkg::SECT_VALID && result.eax[11:4] == 8'h00
                     && result.ebx[31:20] == 12'h000))
        else $error("section type or reserved field wrong");

    sect_hidden_a: assert property (
        q_sect0 && !opted_in |=> result == '0)
        else $error("section published before opt-in");

    run_cover: cover property (encl_req && opted_in ##1 encl_verdict == efe_pkg::EFE_RUN);
    gp_cover: cover property (encl_verdict == efe_pkg::EFE_GP);
    lock_cover: cover property (ctrl_wr && st_reg.lock);
    sect_cover: cover property (q_sect0 && opted_in ##1 result.eax[3:0] == efe_pkg::SECT_VALID);

endmodule

// file: design/efe_pkg.sv
package efe_pkg;

    // Query leaves and sub-leaves
    localparam logic [31:0] LEAF_EXT_FEAT    = 32'h0000_0007;
    localparam logic [31:0] LEAF_ENCLAVE_RES = 32'h0000_0012;
    localparam logic [31:0] SUBLEAF_ZERO     = 32'h0000_0000;
    localparam logic [31:0] SUBLEAF_CAPS     = 32'h0000_0000;
    localparam logic [31:0] SUBLEAF_ATTR     = 32'h0000_0001;
    localparam logic [31:0] SUBLEAF_SECT0    = 32'h0000_0002;

    // Feature flag and control bit positions
    localparam int SUPPORT_POS = 2;
    localparam int LOCK_POS    = 0;
    localparam int OPT_IN_POS  = 18;

    // Capability bit positions of sub-leaf 0 EAX
    localparam int CAP_BASE_POS     = 0;
    localparam int CAP_DYN_POS      = 1;
    localparam int CAP_VCHILD_POS   = 5;
    localparam int CAP_CONFLICT_POS = 6;
    localparam logic [31:0] CAP_DEFINED_MASK = 32'h0000_0063;

    // Values after reset of the control register
    localparam logic [63:0] CTRL_RESET = 64'h0000_0000_0000_0000;

    // Hardware capability values (plain defaults)
    localparam logic        ENCLAVE_SUPPORTED = 1'h1;
    localparam logic [31:0] EXT_FLAGS_OTHER   = 32'h0000_0000;
    localparam logic [31:0] CAP_FLAGS         = 32'h0000_0003;
    localparam logic [31:0] MISC_SELECT       = 32'h0000_0000;
    localparam logic [7:0]  MAX_EXP_LEGACY    = 8'h1F;
    localparam logic [7:0]  MAX_EXP_WIDE      = 8'h24;
    localparam logic [127:0] ATTR_MASK        = 128'h0000_0000_0000_001F_0000_0000_0000_00F6;

    // Section sub-leaf encodings
    localparam logic [3:0] SECT_INVALID = 4'h0;
    localparam logic [3:0] SECT_VALID   = 4'h1;
    localparam logic [3:0] SECT_PROT_CI = 4'h1;
    localparam int         NUM_SECT     = 2;
    localparam int         SECT_IDX_W   = 1;
    localparam int         SECT_ADDR_W  = 40;

    typedef struct packed {
        logic [31:0] leaf;
        logic [31:0] subleaf;
    } efe_query_type;

    typedef struct packed {
        logic [31:0] eax;
        logic [31:0] ebx;
        logic [31:0] ecx;
        logic [31:0] edx;
    } efe_result_type;

    typedef struct packed {
        logic                   valid;
        logic [SECT_ADDR_W-1:0] base;
        logic [SECT_ADDR_W-1:0] size;
    } efe_sect_cfg_type;

    typedef enum logic [1:0] {
        EFE_IDLE,
        EFE_RUN,
        EFE_UD,
        EFE_GP
    } efe_verdict_type;

    typedef struct packed {
        logic            lock;
        logic            opt_in;
        logic            res_valid;
        efe_result_type  res;
        efe_verdict_type verdict;
    } efe_top_state_type;

    localparam efe_top_state_type TOP_RESET = '0;
    localparam efe_sect_cfg_type  SECT_RESET = '0;

endpackage

// file: design/efe_section_slot.sv
`timescale 1ns/100ps
module efe_section_slot (
    input  wire logic                      clock,
    input  wire logic                      rst_n,
    input  wire logic                      wr,
    input  wire efe_pkg::efe_sect_cfg_type cfg,
    output efe_pkg::efe_result_type        result
);
    efe_pkg::efe_sect_cfg_type st_reg;
    efe_pkg::efe_sect_cfg_type st_next;

    always_comb begin
        st_next = st_reg;
        if (wr) begin
            st_next = cfg;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= efe_pkg::SECT_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    // An empty slot answers all zero, which also encodes the invalid type
    always_comb begin
        result = '0;
        if (st_reg.valid) begin
            result.eax = {st_reg.base[19:0], 8'h00, efe_pkg::SECT_VALID};
            result.ebx = {12'h000, st_reg.base[39:20]};
            result.ecx = {st_reg.size[19:0], 8'h00, efe_pkg::SECT_PROT_CI};
            result.edx = {12'h000, st_reg.size[39:20]};
        end
    end
endmodule

// file: tb/efe_feature_enum_tb.sv
`timescale 1ns/100ps
module efe_feature_enum_tb;
    logic                               clock         = 1'b0;
    logic                               rst_n         = 1'b0;
    logic                               query_valid   = 1'b0;
    efe_pkg::efe_query_type             query         = '0;
    logic                               ctrl_wr       = 1'b0;
    logic [63:0]                        ctrl_wdata    = 64'h0;
    logic                               sect_wr       = 1'b0;
    logic [efe_pkg::SECT_IDX_W-1:0]     sect_idx      = '0;
    efe_pkg::efe_sect_cfg_type          sect_cfg      = '0;
    logic                               encl_req      = 1'b0;
    logic                               encl_extra_ud = 1'b0;
    logic                               result_valid;
    efe_pkg::efe_result_type            result;
    logic [63:0]                        ctrl_rdata;
    efe_pkg::efe_verdict_type           encl_verdict;
    logic                               opted_in;
    int                                 fails         = 0;
    int                                 comparisons   = 0;
    efe_pkg::efe_result_type            r;
    logic [31:0]                        flags_before;
    efe_pkg::efe_sect_cfg_type          cfg_a         = '{1'b1, 40'h12_3456_789A, 40'h00_0000_4000};
    efe_pkg::efe_sect_cfg_type          cfg_b         = '{1'b1, 40'h00_0001_0000, 40'h00_0000_1000};

    efe_feature_enum i_dut (
        .clock         (clock),
        .rst_n         (rst_n),
        .query_valid   (query_valid),
        .query         (query),
        .result_valid  (result_valid),
        .result        (result),
        .ctrl_wr       (ctrl_wr),
        .ctrl_wdata    (ctrl_wdata),
        .ctrl_rdata    (ctrl_rdata),
        .sect_wr       (sect_wr),
        .sect_idx      (sect_idx),
        .sect_cfg      (sect_cfg),
        .encl_req      (encl_req),
        .encl_extra_ud (encl_extra_ud),
        .encl_verdict  (encl_verdict),
        .opted_in      (opted_in)
    );

    always #5 clock = ~clock;

    task automatic check(input string name, input logic [127:0] seen, input logic [127:0] expected);
        comparisons++;
        if (seen !== expected) begin
            fails++;
            $display("unexpected %s: expected %h, seen %h", name, expected, seen);
        end
    endtask

    task automatic report_and_stop();
        $display("comparisons %0d, mismatches %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic do_query(input logic [31:0] leaf, input logic [31:0] sub);
        @(negedge clock);
        query_valid = 1'b1;
        query.leaf = leaf;
        query.subleaf = sub;
        @(negedge clock);
        query_valid = 1'b0;
        check("result_valid", {127'h0, result_valid}, 128'h1);
        r = result;
    endtask

    task automatic ctrl_write(input logic [63:0] d, input logic [63:0] exp_rd, input logic exp_on);
        @(negedge clock);
        ctrl_wr = 1'b1;
        ctrl_wdata = d;
        @(negedge clock);
        ctrl_wr = 1'b0;
        check("ctrl_rdata", {64'h0, ctrl_rdata}, {64'h0, exp_rd});
        check("opted_in", {127'h0, opted_in}, {127'h0, exp_on});
    endtask

    task automatic sect_write(input logic idx, input efe_pkg::efe_sect_cfg_type c);
        @(negedge clock);
        sect_wr = 1'b1;
        sect_idx = idx;
        sect_cfg = c;
        @(negedge clock);
        sect_wr = 1'b0;
    endtask

    // Verdict must appear in the single cycle after the attempt and then drop back
    task automatic encl(input logic ud, input efe_pkg::efe_verdict_type exp);
        @(negedge clock);
        encl_req = 1'b1;
        encl_extra_ud = ud;
        @(negedge clock);
        encl_req = 1'b0;
        encl_extra_ud = 1'b0;
        check("encl_verdict", {126'h0, encl_verdict}, {126'h0, exp});
        @(negedge clock);
        check("verdict_idle", {126'h0, encl_verdict}, {126'h0, efe_pkg::EFE_IDLE});
    endtask

    function automatic logic [127:0] sect_exp(input efe_pkg::efe_sect_cfg_type c);
        return {c.base[19:0], 8'h00, 4'h1, 12'h000, c.base[39:20], c.size[19:0], 8'h00, 4'h1, 12'h000, c.size[39:20]};
    endfunction

    initial begin
        #20000;
        fails++;
        report_and_stop();
    end

    initial begin
        repeat (10) @(negedge clock);
        rst_n = 1'b1;
        check("ctrl_after_reset", {ctrl_rdata, 63'h0, opted_in}, 128'h0);
        do_query(efe_pkg::LEAF_EXT_FEAT, efe_pkg::SUBLEAF_ZERO);
        check("support_flag", {127'h0, r.ebx[2]}, {127'h0, efe_pkg::ENCLAVE_SUPPORTED});
        flags_before = r.ebx;
        do_query(efe_pkg::LEAF_ENCLAVE_RES, efe_pkg::SUBLEAF_CAPS);
        check("caps_words", r, {efe_pkg::CAP_FLAGS, efe_pkg::MISC_SELECT, 32'h0000_0000,
              16'h0000, efe_pkg::MAX_EXP_WIDE, efe_pkg::MAX_EXP_LEGACY});
        check("caps_reserved", {96'h0, r.eax & 32'hFFFF_FF9C}, 128'h0);
        do_query(efe_pkg::LEAF_ENCLAVE_RES, efe_pkg::SUBLEAF_ATTR);
        check("attr_mask", r, {efe_pkg::ATTR_MASK[31:0], efe_pkg::ATTR_MASK[63:32],
              efe_pkg::ATTR_MASK[95:64], efe_pkg::ATTR_MASK[127:96]});
        sect_write(1'b0, cfg_a);
        do_query(efe_pkg::LEAF_ENCLAVE_RES, efe_pkg::SUBLEAF_SECT0);
        check("section_not_opted", r, 128'h0);
        encl(1'b1, efe_pkg::EFE_UD);
        encl(1'b0, efe_pkg::EFE_GP);
        ctrl_write(64'h0000_0000_0004_0000, 64'h0000_0000_0004_0000, 1'b0);
        encl(1'b0, efe_pkg::EFE_GP);
        ctrl_write(64'h0000_0000_0000_0001, 64'h0000_0000_0000_0001, 1'b0);
        encl(1'b0, efe_pkg::EFE_GP);
        ctrl_write(64'h0000_0000_0004_0001, 64'h0000_0000_0000_0001, 1'b0);
        // Second reset in mid-run must clear the lock
        @(negedge clock);
        rst_n = 1'b0;
        @(negedge clock);
        check("ctrl_mid_reset", {ctrl_rdata, 63'h0, opted_in}, 128'h0);
        repeat (2) @(negedge clock);
        rst_n = 1'b1;
        sect_write(1'b0, cfg_a);
        // Firmware opts in before any enclave resource is used; one thread only
        ctrl_write(64'h0000_0000_0004_0001, 64'h0000_0000_0004_0001, 1'b1);
        encl(1'b0, efe_pkg::EFE_RUN);
        encl(1'b1, efe_pkg::EFE_UD);
        do_query(efe_pkg::LEAF_EXT_FEAT, efe_pkg::SUBLEAF_ZERO);
        check("flags_unchanged", {96'h0, r.ebx}, {96'h0, flags_before});
        do_query(efe_pkg::LEAF_ENCLAVE_RES, efe_pkg::SUBLEAF_SECT0);
        check("section_words", r, sect_exp(cfg_a));
        sect_write(1'b1, cfg_b);
        ctrl_write(64'h0000_0000_0000_0000, 64'h0000_0000_0004_0001, 1'b1);
        do_query(efe_pkg::LEAF_ENCLAVE_RES, 32'h0000_0003);
        check("section_locked_out", r, 128'h0);
        do_query(efe_pkg::LEAF_ENCLAVE_RES, 32'h0000_0004);
        check("beyond_sections", r, 128'h0);
        do_query(32'h0000_0005, efe_pkg::SUBLEAF_ZERO);
        check("unknown_leaf", r, 128'h0);
        report_and_stop();
    end
endmodule
